/* hw/pmbr_engine.sv */
// PCI master burst read engine, 32-bit PCI side, 64-bit local output side
//
// Summary of operation
// - Address phase loads the burst counter with the requested burst length.
// - First DWORD goes to output bits 31:0, low strobe on, high strobe off.
// - Second DWORD goes to output bits 63:32 and the burst counter drops.
// - After a completed phase with upper DWORD, high strobe on, low strobe off.
// - Third DWORD goes to the lower half, counter drops; halves alternate.
// - Lower-half DWORD asserts low strobe only; local master then reads it.
// - During data phases, initiator ready is asserted in each cycle after local ready was asserted.
// - A data phase completes when initiator ready and target ready are both low.
// - Frame and 64-bit request are deasserted during the last data phase.
// - Moving the final DWORD to the local bus brings the counter to zero.
// - After the last phase: release pins, drop irdy, report normal termination.
// - A final upper DWORD asserts only the high strobe, no address increment.
// - Back in idle, irdy is released and both half strobes are off.
`timescale 1ns/1ps
`default_nettype none

module pmbr_engine #(
  parameter int BURST_W = pmbr_pkg::BURST_W_DEF
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic burst_req_n,
  input wire logic [31:0] start_addr,
  input wire logic [3:0] bus_cmd,
  input wire logic [3:0] byte_en_n,
  input wire logic [BURST_W-1:0] burst_len,
  input wire logic local_master_ready_n,
  input wire logic trdy_n,
  input wire logic devsel_n,
  input wire logic [31:0] ad_in,
  output pmbr_pkg::pmbr_pci_out_t pci_o,
  output pmbr_pkg::pmbr_pci_oe_t pci_oe,
  output logic [63:0] l_data_out,
  output logic low_half_xfer_strobe_n,
  output logic high_half_xfer_strobe_n,
  output logic [BURST_W-1:0] burst_words_remaining,
  output logic [3:0] master_transaction_state,
  output logic [1:0] master_end_reason
);

  ////////////////////////////////////////////////////////////////////////////
  // State and shared terms

  pmbr_pkg::pmbr_state_t state_q;
  logic [BURST_W-1:0] len_q;
  logic [BURST_W-1:0] pci_left_q;
  logic half_q;
  logic xfer;
  logic last_xfer;
  logic req_take;
  logic [BURST_W-1:0] one_w;

  assign one_w = BURST_W'(1);
  // Data phase done: both ready lines low in one clock
  assign xfer = (state_q == pmbr_pkg::ST_DATA) && !pci_o.irdy_n && !trdy_n;
  assign last_xfer = xfer && (pci_left_q == one_w);
  assign req_take = (state_q == pmbr_pkg::ST_IDLE) && !burst_req_n;

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer

  // Request, address, data phases, termination
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      state_q <= pmbr_pkg::ST_IDLE;
    else
      case (state_q)
        pmbr_pkg::ST_IDLE: if (req_take) state_q <= pmbr_pkg::ST_LOAD;
        pmbr_pkg::ST_LOAD: state_q <= pmbr_pkg::ST_ADDR;
        pmbr_pkg::ST_ADDR: state_q <= pmbr_pkg::ST_DATA;
        pmbr_pkg::ST_DATA: if (last_xfer) state_q <= pmbr_pkg::ST_TERM;
        pmbr_pkg::ST_TERM: state_q <= pmbr_pkg::ST_IDLE;
        default: state_q <= pmbr_pkg::ST_IDLE;
      endcase
  end

  // Latch the requested burst length; zero length is taken as one
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      len_q <= '0;
    else if (req_take)
      len_q <= (burst_len == '0) ? one_w : burst_len;
  end

  // Phases still to complete on the PCI side
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      pci_left_q <= '0;
    else if (state_q == pmbr_pkg::ST_ADDR)
      pci_left_q <= len_q;
    else if (xfer)
      pci_left_q <= pci_left_q - one_w;
  end

  ////////////////////////////////////////////////////////////////////////////
  // PCI pin drive

  // Frame, 64-bit request, command/byte enables, address
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pci_o.frame_n <= 1'b1;
      pci_o.req64_n <= 1'b1;
      pci_o.cbe_n <= pmbr_pkg::CBE_RST;
      pci_o.ad <= pmbr_pkg::AD_RST;
      pci_oe.frame <= 1'b0;
      pci_oe.req64 <= 1'b0;
      pci_oe.cbe <= 1'b0;
      pci_oe.ad <= 1'b0;
    end
    else if (state_q == pmbr_pkg::ST_LOAD)
    begin
      // Address phase starts
      pci_o.frame_n <= 1'b0;
      pci_o.req64_n <= 1'b0;
      pci_o.cbe_n <= bus_cmd;
      pci_o.ad <= start_addr;
      pci_oe.frame <= 1'b1;
      pci_oe.req64 <= 1'b1;
      pci_oe.cbe <= 1'b1;
      pci_oe.ad <= 1'b1;
    end
    else if (state_q == pmbr_pkg::ST_ADDR)
    begin
      // Turnaround: release AD, byte enables, frame off for one-word burst
      pci_o.frame_n <= (len_q == one_w);
      pci_o.req64_n <= (len_q == one_w);
      pci_o.cbe_n <= byte_en_n;
      pci_oe.ad <= 1'b0;
    end
    else if (xfer && pci_left_q == BURST_W'(2))
    begin
      pci_o.frame_n <= 1'b1;
      pci_o.req64_n <= 1'b1;
    end
    else if (last_xfer)
    begin
      pci_oe.frame <= 1'b0;
      pci_oe.req64 <= 1'b0;
      pci_oe.cbe <= 1'b0;
      pci_o.cbe_n <= pmbr_pkg::CBE_RST;
    end
  end

  // Initiator ready follows local ready of the previous cycle
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pci_o.irdy_n <= 1'b1;
      pci_oe.irdy <= 1'b0;
    end
    else if (last_xfer)
      pci_o.irdy_n <= 1'b1;
    else if (state_q == pmbr_pkg::ST_ADDR || state_q == pmbr_pkg::ST_DATA)
    begin
      pci_o.irdy_n <= local_master_ready_n;
      pci_oe.irdy <= 1'b1;
    end
    else if (state_q == pmbr_pkg::ST_TERM)
      pci_oe.irdy <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Local output side

  // Completed DWORD lands on alternating halves with its strobe
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      l_data_out <= 64'h0;
      half_q <= 1'b0;
      low_half_xfer_strobe_n <= 1'b1;
      high_half_xfer_strobe_n <= 1'b1;
    end
    else if (state_q == pmbr_pkg::ST_ADDR)
    begin
      half_q <= 1'b0;
      low_half_xfer_strobe_n <= 1'b1;
      high_half_xfer_strobe_n <= 1'b1;
    end
    else if (xfer && !half_q)
    begin
      l_data_out[31:0] <= ad_in;
      half_q <= 1'b1;
      low_half_xfer_strobe_n <= 1'b0;
      high_half_xfer_strobe_n <= 1'b1;
    end
    else if (xfer)
    begin
      l_data_out[63:32] <= ad_in;
      half_q <= 1'b0;
      low_half_xfer_strobe_n <= 1'b1;
      high_half_xfer_strobe_n <= 1'b0;
    end
    else
    begin
      // Strobes last one cycle per DWORD; off in idle
      low_half_xfer_strobe_n <= 1'b1;
      high_half_xfer_strobe_n <= 1'b1;
    end
  end

  // Words left for the local side
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      burst_words_remaining <= '0;
    else if (state_q == pmbr_pkg::ST_ADDR)
      burst_words_remaining <= len_q;
    else if (xfer)
      burst_words_remaining <= burst_words_remaining - one_w;
  end

  // Status and termination, held until the next request
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      master_transaction_state <= pmbr_pkg::STAT_IDLE;
      master_end_reason <= pmbr_pkg::END_NONE;
    end
    else if (req_take)
    begin
      master_transaction_state <= pmbr_pkg::STAT_ADDR_LOAD;
      master_end_reason <= pmbr_pkg::END_NONE;
    end
    else if (state_q == pmbr_pkg::ST_LOAD)
      master_transaction_state <= pmbr_pkg::STAT_BUS_TRANS;
    else if (last_xfer)
    begin
      master_transaction_state <= pmbr_pkg::STAT_BUS_TERM;
      master_end_reason <= pmbr_pkg::END_NORMAL;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  irdy_follows_ready_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state_q == pmbr_pkg::ST_DATA && !local_master_ready_n && !last_xfer) |=> !pci_o.irdy_n)
    else $error("irdy not asserted after local ready");

  count_loaded_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state_q == pmbr_pkg::ST_ADDR) |=> burst_words_remaining == $past(len_q))
    else $error("burst counter not loaded at address phase");

  low_half_data_a: assert property (@(posedge clk) disable iff (!rst_n)
    (xfer && !half_q) |=> (!low_half_xfer_strobe_n && high_half_xfer_strobe_n
      && l_data_out[31:0] == $past(ad_in)))
    else $error("lower half DWORD or strobes wrong");

  high_half_data_a: assert property (@(posedge clk) disable iff (!rst_n)
    (xfer && half_q) |=> (low_half_xfer_strobe_n && !high_half_xfer_strobe_n
      && l_data_out[63:32] == $past(ad_in)))
    else $error("upper half DWORD or strobes wrong");

  halves_alternate_a: assert property (@(posedge clk) disable iff (!rst_n)
    xfer |=> (half_q != $past(half_q)))
    else $error("halves do not alternate");

  count_step_a: assert property (@(posedge clk) disable iff (!rst_n)
    xfer |=> burst_words_remaining == $past(burst_words_remaining) - one_w)
    else $error("burst counter did not decrement");

  frame_last_a: assert property (@(posedge clk) disable iff (!rst_n)
    (xfer && pci_left_q == BURST_W'(2)) |=> (pci_o.frame_n && pci_o.req64_n
      && !pci_o.irdy_n == !$past(local_master_ready_n)))
    else $error("frame not dropped for last data phase");

  term_report_a: assert property (@(posedge clk) disable iff (!rst_n)
    last_xfer |=> (!pci_oe.frame && !pci_oe.cbe && pci_o.irdy_n
      && burst_words_remaining == '0
      && master_transaction_state == pmbr_pkg::STAT_BUS_TERM
      && master_end_reason == pmbr_pkg::END_NORMAL))
    else $error("termination not reported correctly");

  idle_release_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state_q == pmbr_pkg::ST_TERM) |=> (!pci_oe.irdy && low_half_xfer_strobe_n
      && high_half_xfer_strobe_n) [*2])
    else $error("irdy or strobes not released in idle");

  status_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state_q == pmbr_pkg::ST_IDLE && burst_req_n) |=> ($stable(master_transaction_state)
      && $stable(master_end_reason)))
    else $error("status changed without a request");

endmodule

`default_nettype wire

/* pkg/pmbr_pkg.sv */
// Package for the PCI master burst read engine with 64-bit local output
package pmbr_pkg;

  // Local transaction status codes
  localparam logic [3:0] STAT_IDLE = 4'h0;
  localparam logic [3:0] STAT_ADDR_LOAD = 4'h1;
  localparam logic [3:0] STAT_BUS_TRANS = 4'h2;
  localparam logic [3:0] STAT_BUS_TERM = 4'h3;

  // Termination reason codes
  localparam logic [1:0] END_NONE = 2'h0;
  localparam logic [1:0] END_NORMAL = 2'h1;

  // Default width of the burst length and counters
  localparam int BURST_W_DEF = 8;

  // Reset values of the driven PCI pins
  localparam logic [31:0] AD_RST = 32'h0000_0000;
  localparam logic [3:0] CBE_RST = 4'hf;

  // Engine states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_LOAD,
    ST_ADDR,
    ST_DATA,
    ST_TERM
  } pmbr_state_t;

  // Values driven onto the PCI pins
  typedef struct packed {
    logic frame_n;
    logic req64_n;
    logic irdy_n;
    logic [3:0] cbe_n;
    logic [31:0] ad;
  } pmbr_pci_out_t;

  // Output enables, high while the engine drives the pin
  typedef struct packed {
    logic frame;
    logic req64;
    logic irdy;
    logic cbe;
    logic ad;
  } pmbr_pci_oe_t;

endpackage

/* tb/pmbr_target_model.sv */
// PCI target model that answers burst reads with a counting data pattern
`timescale 1ns/1ps
`default_nettype none
module pmbr_target_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire pmbr_pkg::pmbr_pci_out_t pci_o,
  input wire pmbr_pkg::pmbr_pci_oe_t pci_oe,
  input wire logic stall,
  input wire logic [31:0] base,
  output logic trdy_n,
  output logic devsel_n,
  output logic [31:0] ad_in
);
  logic active_q;
  logic [31:0] idx_q;
  logic [31:0] last_q;
  logic done;
  // Wire level of AD; an undriven bus toggles every cycle
  assign ad_in = pci_oe.ad ? pci_o.ad : (active_q ? base + idx_q : ~last_q);
  assign done = active_q && !pci_o.irdy_n && !trdy_n;
  // Claim, wait states, data advance and turnaround
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      active_q <= 1'b0;
      idx_q <= 32'h0;
      last_q <= 32'h0;
      trdy_n <= 1'b1;
      devsel_n <= 1'b1;
    end
    else
    begin
      last_q <= ad_in;
      if (pci_oe.ad && !pci_o.frame_n)
      begin
        active_q <= 1'b1;
        idx_q <= 32'h0;
        devsel_n <= 1'b0;
        trdy_n <= stall;
      end
      else if (done && pci_o.frame_n)
      begin
        active_q <= 1'b0;
        trdy_n <= 1'b1;
        devsel_n <= 1'b1;
      end
      else if (active_q)
      begin
        if (done)
          idx_q <= idx_q + 32'h1;
        trdy_n <= stall;
      end
    end
  end
endmodule
`default_nettype wire

/* tb/pmbr_engine_bench.sv */
// Self-checking bench for the burst read engine
`timescale 1ns/1ps
`default_nettype none
module pmbr_engine_bench;
  logic clk, rst_n, burst_req_n, local_master_ready_n, trdy_n, devsel_n, stall, busy;
  logic [31:0] start_addr, ad_in, base;
  logic [3:0] bus_cmd, byte_en_n, master_transaction_state;
  logic [7:0] burst_len, burst_words_remaining;
  logic [63:0] l_data_out;
  logic low_half_xfer_strobe_n, high_half_xfer_strobe_n;
  logic [1:0] master_end_reason;
  pmbr_pkg::pmbr_pci_out_t pci_o;
  pmbr_pkg::pmbr_pci_oe_t pci_oe;
  int mismatches = 0, samples_checked = 0, slow_lm = 0, slow_t = 0;
  int len_exp = 1, done_cnt = 0, pend_k = 0;
  logic pend_q = 0, term_q = 0, idle_q = 0, rdy_q = 1, cmp;

  pmbr_engine #(.BURST_W(8)) dut (.clk(clk), .rst_n(rst_n), .burst_req_n(burst_req_n),
    .start_addr(start_addr), .bus_cmd(bus_cmd), .byte_en_n(byte_en_n),
    .burst_len(burst_len), .local_master_ready_n(local_master_ready_n), .trdy_n(trdy_n),
    .devsel_n(devsel_n), .ad_in(ad_in), .pci_o(pci_o), .pci_oe(pci_oe),
    .l_data_out(l_data_out), .low_half_xfer_strobe_n(low_half_xfer_strobe_n),
    .high_half_xfer_strobe_n(high_half_xfer_strobe_n),
    .burst_words_remaining(burst_words_remaining),
    .master_transaction_state(master_transaction_state),
    .master_end_reason(master_end_reason));
  pmbr_target_model target (.clk(clk), .rst_n(rst_n), .pci_o(pci_o), .pci_oe(pci_oe),
    .stall(stall), .base(base), .trdy_n(trdy_n), .devsel_n(devsel_n), .ad_in(ad_in));

  ////////////////////////////////////////////////////////////////////////
  // Clock and random stalls of both far parties
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(negedge clk)
  begin
    local_master_ready_n <= busy ? ($urandom_range(0, 99) < slow_lm) : 1'b1;
    stall <= ($urandom_range(0, 99) < slow_t);
  end

  // Compare and count
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  // Verdict and end of run
  task automatic complete_run();
    $display("checks=%0d mismatches=%0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Monitor: values seen at an edge were launched at the edge before
  always @(posedge clk)
  begin
    if (pend_q && pend_k % 2 == 0)
    begin
      check({62'h0, low_half_xfer_strobe_n, high_half_xfer_strobe_n}, 64'h1);
      check({32'h0, l_data_out[31:0]}, {32'h0, base + pend_k});
    end
    else if (pend_q)
    begin
      check({62'h0, low_half_xfer_strobe_n, high_half_xfer_strobe_n}, 64'h2);
      check({32'h0, l_data_out[63:32]}, {32'h0, base + pend_k});
    end
    else if (rst_n)
      check({62'h0, low_half_xfer_strobe_n, high_half_xfer_strobe_n}, 64'h3);
    if (pci_oe.ad)
      check({28'h0, pci_o.cbe_n, pci_o.ad}, {28'h0, bus_cmd, start_addr});
    if (pend_q)
      check(64'(burst_words_remaining), 64'(len_exp - pend_k - 1));
    if (term_q)
    begin
      check({58'h0, master_transaction_state, master_end_reason},
        {58'h0, pmbr_pkg::STAT_BUS_TERM, pmbr_pkg::END_NORMAL});
      check({59'h0, pci_o.irdy_n, pci_oe.frame, pci_oe.req64, pci_oe.cbe, pci_oe.ad},
        64'h10);
    end
    if (idle_q)
      check({63'h0, pci_oe.irdy}, 64'h0);
    if (pci_oe.irdy && master_transaction_state === pmbr_pkg::STAT_BUS_TRANS && !rdy_q)
      check({63'h0, pci_o.irdy_n}, 64'h0);
    cmp = rst_n && pci_oe.irdy && !pci_o.irdy_n && !trdy_n;
    if (cmp)
    begin
      check({62'h0, pci_o.frame_n, pci_o.req64_n},
        {62'h0, {2{done_cnt == len_exp - 1}}});
      check(64'(pci_o.cbe_n), 64'(byte_en_n));
    end
    idle_q = term_q;
    term_q = cmp && done_cnt == len_exp - 1;
    pend_q = cmp;
    pend_k = done_cnt;
    // Completion count restarts when a new request is taken
    done_cnt = (master_transaction_state === pmbr_pkg::STAT_ADDR_LOAD) ? 0 : done_cnt + int'(cmp);
    rdy_q = local_master_ready_n;
  end

  // One burst read with given stall rates, then an idle gap
  task automatic burst(input logic [7:0] len, input int lm_p, input int t_p);
    int n;
    @(negedge clk);
    slow_lm = lm_p;
    slow_t = t_p;
    base = $urandom;
    start_addr = $urandom;
    bus_cmd = 4'($urandom);
    byte_en_n = 4'($urandom);
    burst_len = len;
    len_exp = (len == 8'h0) ? 1 : int'(len);
    busy = 1'b1;
    burst_req_n = 1'b0;
    n = 0;
    while (master_transaction_state !== pmbr_pkg::STAT_ADDR_LOAD && n < 20)
    begin
      @(negedge clk);
      n++;
    end
    check(64'(n < 20), 64'h1);
    burst_req_n = 1'b1;
    n = 0;
    while (!idle_q && n < 4000)
    begin
      @(negedge clk);
      n++;
    end
    check(64'(n < 4000), 64'h1);
    busy = 1'b0;
    check(64'(done_cnt), 64'(len_exp));
    repeat (3)
    begin
      @(negedge clk);
      check({62'h0, master_end_reason}, {62'h0, pmbr_pkg::END_NORMAL});
      check({60'h0, master_transaction_state}, {60'h0, pmbr_pkg::STAT_BUS_TERM});
    end
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Reset, corner lengths, then random bursts
  initial
  begin
    void'($urandom(54315));
    rst_n = 1'b0;
    burst_req_n = 1'b1;
    busy = 1'b0;
    start_addr = 32'h0;
    base = 32'h0;
    bus_cmd = 4'h6;
    byte_en_n = 4'h0;
    burst_len = 8'h1;
    repeat (8) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    burst(8'h1, 0, 0);
    burst(8'h2, 0, 0);
    burst(8'h3, 0, 0);
    burst(8'h4, 0, 0);
    burst(8'h0, 0, 0);
    burst(8'hff, 30, 30);
    repeat (25) burst(8'($urandom_range(1, 20)), $urandom_range(0, 60), $urandom_range(0, 60));
    complete_run();
  end

  // Watchdog against a hung burst
  initial
  begin
    repeat (60000) @(posedge clk);
    mismatches++;
    complete_run();
  end
endmodule
`default_nettype wire
